// >>> ipw_pkg.sv
package ipw_pkg;

    // ************************************************************
    // register map, byte addresses on the apb bus
    // ************************************************************
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] OFS_VSTART = 8'h00;
    localparam logic [7:0] OFS_VSIZE = 8'h04;
    localparam logic [7:0] OFS_HSTART = 8'h08;
    localparam logic [7:0] OFS_HSIZE = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_GATE = 8'h14;
    localparam logic [7:0] OFS_CTRL = 8'h18;
    localparam logic [7:0] OFS_PIXG = 8'h1c;
    localparam logic [7:0] OFS_ISTAT = 8'h20;
    localparam logic [7:0] OFS_IMASK = 8'h24;

    // ************************************************************
    // field widths and reset values
    // ************************************************************
    localparam int unsigned POS_W = 16;
    localparam int unsigned SIZE_W = 13;
    localparam int unsigned PIXG_W = 4;
    localparam int unsigned EV_W = 3;
    localparam logic [15:0] VSTART_RST = 16'h0000;
    localparam logic [12:0] VSIZE_RST = 13'h0000;
    localparam logic [15:0] HSTART_RST = 16'h0000;
    localparam logic [12:0] HSIZE_RST = 13'h0001;
    localparam logic GATE_RST = 1'b0;
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [3:0] PIXG_RST = 4'h0;
    localparam logic [2:0] IMASK_RST = 3'h0;

    // interrupt event positions
    localparam int unsigned EV_FRAME = 0;
    localparam int unsigned EV_DONE = 1;
    localparam int unsigned EV_BOXERR = 2;

    // status word, bit 4 down to bit 0
    typedef struct packed {
        logic histogram_busy;
        logic histogram_bank;
        logic boundary_calc_busy;
        logic boxcar_busy;
        logic boxcar_error;
    } ipw_engine_sts_t;

    // control word, bit 3 down to bit 0
    typedef struct packed {
        logic boundary_calc_enable;
        logic histogram_enable;
        logic boxcar_enable;
        logic pipe_enable;
    } ipw_enables_t;

    // processing window towards the pipe
    typedef struct packed {
        logic frame_start;
        logic line_active;
        logic pixel_active;
        logic in_window;
    } ipw_window_t;

endpackage

// >>> ipw_window_regs.sv
`timescale 1ns/1ps

module ipw_window_regs (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // apb slave
    input wire logic [ipw_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // sync pins from the sensor side
    input wire logic vertical_sync,
    input wire logic horizontal_sync,
    // engine state, same clock
    input wire ipw_pkg::ipw_engine_sts_t engine_sts,
    // control outputs
    output logic register_interface_clock,
    output logic [ipw_pkg::PIXG_W-1:0] pixel_clock_gate,
    output ipw_pkg::ipw_enables_t enables,
    output ipw_pkg::ipw_window_t window,
    output logic irq
);

    // ************************************************************
    // reset release and sync pin capture
    // ************************************************************
    logic rst_s1_q;
    logic rst_sync_n;
    logic vs_s1_q, vs_s2_q, vs_s3_q;
    logic hs_s1_q, hs_s2_q, hs_s3_q;
    logic vs_rise, hs_rise;

    // reset leaves through two flops so release is clean
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_q <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_sync_n <= rst_s1_q;
        end
    end

    // two stage synchronisers, third flop only for edge finding
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            vs_s1_q <= 1'b0;
            vs_s2_q <= 1'b0;
            vs_s3_q <= 1'b0;
            hs_s1_q <= 1'b0;
            hs_s2_q <= 1'b0;
            hs_s3_q <= 1'b0;
        end else begin
            vs_s1_q <= vertical_sync;
            vs_s2_q <= vs_s1_q;
            vs_s3_q <= vs_s2_q;
            hs_s1_q <= horizontal_sync;
            hs_s2_q <= hs_s1_q;
            hs_s3_q <= hs_s2_q;
        end
    end

    assign vs_rise = vs_s2_q & ~vs_s3_q;
    assign hs_rise = hs_s2_q & ~hs_s3_q;

    // ************************************************************
    // register file over apb
    // ************************************************************
    logic [15:0] vstart_q, vstart_d;
    logic [12:0] vsize_q, vsize_d;
    logic [15:0] hstart_q, hstart_d;
    logic [12:0] hsize_q, hsize_d;
    logic gate_q, gate_d;
    logic [3:0] ctrl_q, ctrl_d;
    logic [3:0] pixg_q, pixg_d;
    logic [2:0] imask_q, imask_d;
    logic [2:0] istat_q, istat_d;
    logic [31:0] rdata_q, rdata_d;
    logic [2:0] events;
    logic setup, access, mapped, exempt, wr_ok;

    assign setup = psel & ~penable;
    assign access = psel & penable;

    // decode: which offsets exist, which survive a closed gate
    always_comb begin
        mapped = 1'b1;
        exempt = 1'b0;
        case (paddr)
            ipw_pkg::OFS_VSTART, ipw_pkg::OFS_VSIZE,
            ipw_pkg::OFS_HSTART, ipw_pkg::OFS_HSIZE,
            ipw_pkg::OFS_STATUS, ipw_pkg::OFS_ISTAT,
            ipw_pkg::OFS_IMASK: exempt = 1'b0;
            ipw_pkg::OFS_GATE, ipw_pkg::OFS_CTRL,
            ipw_pkg::OFS_PIXG: exempt = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // writes to window regs only count with the gate on
    assign wr_ok = access & pwrite & (gate_q | exempt);

    // next values of the writable registers
    always_comb begin
        vstart_d = vstart_q;
        vsize_d = vsize_q;
        hstart_d = hstart_q;
        hsize_d = hsize_q;
        gate_d = gate_q;
        ctrl_d = ctrl_q;
        pixg_d = pixg_q;
        imask_d = imask_q;
        if (wr_ok) begin
            case (paddr)
                ipw_pkg::OFS_VSTART: vstart_d = pwdata[15:0];
                ipw_pkg::OFS_VSIZE: vsize_d = pwdata[12:0];
                ipw_pkg::OFS_HSTART: hstart_d = pwdata[15:0];
                ipw_pkg::OFS_HSIZE: hsize_d = {pwdata[12:1], 1'b1};
                ipw_pkg::OFS_GATE: gate_d = pwdata[0];
                ipw_pkg::OFS_CTRL: ctrl_d = pwdata[3:0];
                ipw_pkg::OFS_PIXG: pixg_d = pwdata[3:0];
                ipw_pkg::OFS_IMASK: imask_d = pwdata[2:0];
                default: ;
            endcase
        end
    end

    // read data is latched in setup so the access cycle is zero wait
    always_comb begin
        rdata_d = rdata_q;
        if (setup) begin
            case (paddr)
                ipw_pkg::OFS_VSTART: rdata_d = {16'h0000, vstart_q};
                ipw_pkg::OFS_VSIZE: rdata_d = {19'h0, vsize_q};
                ipw_pkg::OFS_HSTART: rdata_d = {16'h0000, hstart_q};
                ipw_pkg::OFS_HSIZE: rdata_d = {19'h0, hsize_q};
                ipw_pkg::OFS_STATUS: rdata_d = {27'h0, engine_sts};
                ipw_pkg::OFS_GATE: rdata_d = {31'h0, gate_q};
                ipw_pkg::OFS_CTRL: rdata_d = {28'h0, ctrl_q};
                ipw_pkg::OFS_PIXG: rdata_d = {28'h0, pixg_q};
                ipw_pkg::OFS_ISTAT: rdata_d = {29'h0, istat_q};
                ipw_pkg::OFS_IMASK: rdata_d = {29'h0, imask_q};
                default: rdata_d = 32'h00000000;
            endcase
        end
    end

    // sticky events; a read clears only what it returned, so a new
    // event in the same cycle survives
    always_comb begin
        istat_d = istat_q;
        if (access & ~pwrite & (paddr == ipw_pkg::OFS_ISTAT)) begin
            istat_d = istat_q & ~rdata_q[2:0];
        end
        istat_d = istat_d | events;
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            vstart_q <= ipw_pkg::VSTART_RST;
            vsize_q <= ipw_pkg::VSIZE_RST;
            hstart_q <= ipw_pkg::HSTART_RST;
            hsize_q <= ipw_pkg::HSIZE_RST;
            gate_q <= ipw_pkg::GATE_RST;
            ctrl_q <= ipw_pkg::CTRL_RST;
            pixg_q <= ipw_pkg::PIXG_RST;
            imask_q <= ipw_pkg::IMASK_RST;
            istat_q <= 3'h0;
            rdata_q <= 32'h00000000;
        end else begin
            vstart_q <= vstart_d;
            vsize_q <= vsize_d;
            hstart_q <= hstart_d;
            hsize_q <= hsize_d;
            gate_q <= gate_d;
            ctrl_q <= ctrl_d;
            pixg_q <= pixg_d;
            imask_q <= imask_d;
            istat_q <= istat_d;
            rdata_q <= rdata_d;
        end
    end

    // bus answers and control outputs
    assign prdata = rdata_q;
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;
    assign register_interface_clock = gate_q;
    assign pixel_clock_gate = pixg_q;
    assign enables = ipw_pkg::ipw_enables_t'(ctrl_q);
    assign irq = |(istat_q & imask_q);

    // ************************************************************
    // line and pixel counters, window compare
    // ************************************************************
    logic [15:0] line_q, line_d, pix_q, pix_d;
    logic line_vld_q, line_vld_d, pix_vld_q, pix_vld_d;
    logic first_q, first_d, boxerr_q;
    logic [16:0] line_off, pix_off;
    logic vwin, hwin, last_px;
    ipw_pkg::ipw_window_t win_d, win_q;

    // vertical sync arms, first horizontal sync after it is line 0
    always_comb begin
        line_d = line_q;
        line_vld_d = line_vld_q;
        first_d = first_q;
        if (vs_rise) begin
            line_d = 16'h0000;
            line_vld_d = hs_rise;
            first_d = ~hs_rise;
        end else if (hs_rise) begin
            if (first_q) begin
                line_vld_d = 1'b1;
                first_d = 1'b0;
            end else if (line_q == 16'hffff) begin
                line_vld_d = 1'b0; // past any reachable start
            end else begin
                line_d = line_q + 16'h0001;
            end
        end
    end

    // one pixel per core clock from the horizontal sync edge
    always_comb begin
        pix_d = pix_q;
        pix_vld_d = pix_vld_q;
        if (hs_rise) begin
            pix_d = 16'h0000;
            pix_vld_d = 1'b1;
        end else if (pix_vld_q) begin
            if (pix_q == 16'hffff) begin
                pix_vld_d = 1'b0;
            end else begin
                pix_d = pix_q + 16'h0001;
            end
        end
    end

    // offsets into the window; a borrow means before the start
    assign line_off = {1'b0, line_q} - {1'b0, vstart_q};
    assign pix_off = {1'b0, pix_q} - {1'b0, hstart_q};
    assign vwin = line_vld_q & ~line_off[16]
        & (line_off[15:0] <= {3'h0, vsize_q});
    assign hwin = pix_vld_q & ~pix_off[16]
        & (pix_off[15:0] <= {3'h0, hsize_q});
    assign last_px = vwin & hwin & (line_off[15:0] == {3'h0, vsize_q})
        & (pix_off[15:0] == {3'h0, hsize_q});

    // window flags to the pipe and interrupt events
    always_comb begin
        win_d.frame_start = vs_rise;
        win_d.line_active = vwin;
        win_d.pixel_active = hwin;
        win_d.in_window = vwin & hwin;
        events = 3'h0;
        events[ipw_pkg::EV_FRAME] = vs_rise;
        events[ipw_pkg::EV_DONE] = last_px;
        events[ipw_pkg::EV_BOXERR] = engine_sts.boxcar_error & ~boxerr_q;
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            line_q <= 16'h0000;
            line_vld_q <= 1'b0;
            first_q <= 1'b0;
            pix_q <= 16'h0000;
            pix_vld_q <= 1'b0;
            win_q <= '0;
            boxerr_q <= 1'b0;
        end else begin
            line_q <= line_d;
            line_vld_q <= line_vld_d;
            first_q <= first_d;
            pix_q <= pix_d;
            pix_vld_q <= pix_vld_d;
            win_q <= win_d;
            boxerr_q <= engine_sts.boxcar_error;
        end
    end

    assign window = win_q;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_sync_n);

    chk_vstart_bound: assert property (
        window.line_active |-> $past(line_q) >= $past(vstart_q))
        else $error("line active before vertical start");
    chk_vsize_bound: assert property (
        window.line_active |->
        ($past(line_q) - $past(vstart_q)) <= {3'h0, $past(vsize_q)})
        else $error("line active beyond vertical size");
    chk_hstart_bound: assert property (
        window.pixel_active |-> $past(pix_q) >= $past(hstart_q))
        else $error("pixel active before horizontal start");
    chk_hsize_bound: assert property (
        window.pixel_active |->
        ($past(pix_q) - $past(hstart_q)) <= {3'h0, $past(hsize_q)})
        else $error("pixel active beyond horizontal size");
    chk_hsize_lsb: assert property (hsize_q[0])
        else $error("horizontal size bit 0 lost");
    chk_status_read: assert property (
        setup && paddr == ipw_pkg::OFS_STATUS |=>
        prdata[4:0] == $past(engine_sts) && prdata[31:5] == 27'h0)
        else $error("status read does not match engine state");
    chk_gate_output: assert property (
        wr_ok && paddr == ipw_pkg::OFS_GATE |=>
        register_interface_clock == $past(pwdata[0]))
        else $error("gate bit not driving register clock");
    chk_gate_block: assert property (
        access && pwrite && !gate_q && paddr == ipw_pkg::OFS_VSTART
        |=> $stable(vstart_q))
        else $error("write taken while register clock off");
    chk_read_gated: assert property (
        setup && !gate_q && paddr == ipw_pkg::OFS_VSIZE |=>
        pready && prdata[12:0] == $past(vsize_q))
        else $error("read refused while register clock off");
    chk_sync_restart: assert property (
        hs_rise && !vs_rise |=> pix_q == 16'h0000 ##1 pix_q == 16'h0001)
        else $error("pixel counter not restarted");

    // sticky set wins over a clearing read in the same cycle
    chk_irq_sticky: assert property (
        events != 3'h0 |=> (istat_q & $past(events)) == $past(events))
        else $error("interrupt event lost");
    // a read of the event word clears only what it returned
    chk_irq_clear: assert property (
        access && !pwrite && paddr == ipw_pkg::OFS_ISTAT && events == 3'h0
        |=> (istat_q & $past(rdata_q[2:0])) == 3'h0)
        else $error("interrupt event not cleared by read");
    // enables must stay writable with the register clock off
    chk_gate_exempt: assert property (
        access && pwrite && !gate_q && paddr == ipw_pkg::OFS_CTRL
        |=> ctrl_q == $past(pwdata[3:0]))
        else $error("enable write refused while register clock off");
    chk_line_restart: assert property (
        vs_rise |=> line_q == 16'h0000)
        else $error("line counter not restarted");
    chk_frame_pulse: assert property (
        window.frame_start |=> !window.frame_start)
        else $error("frame start longer than one cycle");

    // covers for the main scenarios
    cov_window_done: cover property (events[ipw_pkg::EV_DONE]);
    cov_gated_write: cover property (access && pwrite && !gate_q && !exempt);
    cov_status_clear: cover property (
        access && !pwrite && paddr == ipw_pkg::OFS_ISTAT && istat_q != 3'h0);
    cov_frame_start: cover property (window.frame_start);
    cov_gated_read: cover property (setup && !gate_q && !pwrite);

endmodule

// >>> ipw_sensor_model.sv
`timescale 1ns/1ps

module ipw_sensor_model #(
    parameter int LINES = 6,
    parameter int LINE_LEN = 20
) (
    // clock and request
    core_clk,
    frame_req,
    // sync pins
    vertical_sync,
    horizontal_sync,
    // progress
    line_idx,
    frame_busy
);
    input wire logic core_clk;
    input wire logic frame_req;
    output logic vertical_sync;
    output logic horizontal_sync;
    output int line_idx;
    output logic frame_busy;

    int cyc;
    int n;

    // ************************************************************
    // frame generator
    // ************************************************************
    initial begin
        vertical_sync = 1'b0;
        horizontal_sync = 1'b0;
        frame_busy = 1'b0;
        line_idx = -1;
        cyc = 0;
    end

    assign n = cyc + 1;

    // pins idle low between frames, so every frame opens with a clean rise
    always @(posedge core_clk) begin
        if (!frame_busy) begin
            if (frame_req) begin
                frame_busy <= 1'b1;
                cyc <= 0;
                line_idx <= -1;
                vertical_sync <= 1'b1;
            end
        end else begin
            cyc <= n;
            vertical_sync <= (n < 2);
            horizontal_sync <= (n >= 4) && ((n - 4) % LINE_LEN < 2) && (n < 4 + LINES * LINE_LEN);
            if ((n >= 4) && ((n - 4) % LINE_LEN == 0) && (n < 4 + LINES * LINE_LEN)) begin
                line_idx <= line_idx + 1;
            end
            if (n == 14 + LINES * LINE_LEN) begin
                frame_busy <= 1'b0;
            end
        end
    end
endmodule

// >>> tb_ipw_window_regs.sv
`timescale 1ns/1ps

module tb_ipw_window_regs;
    // ************************************************************
    // bench signals
    // ************************************************************
    typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e;} ipw_row_t;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic vertical_sync;
    logic horizontal_sync;
    ipw_pkg::ipw_engine_sts_t engine_sts = '0;
    logic register_interface_clock;
    logic [3:0] pixel_clock_gate;
    ipw_pkg::ipw_enables_t enables;
    ipw_pkg::ipw_window_t window;
    logic irq;
    logic frame_req = 1'b0;
    logic frame_busy;
    int line_idx;
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;
    int win_cnt = 0;
    int first_line = -1;
    int fs_cnt = 0;
    int ln_cnt = 0;
    int px_cnt = 0;
    logic [31:0] rd;
    logic err;
    ipw_row_t rows [15] = '{
        '{0, 8'h00, 32'h0, 32'h0}, '{0, 8'h04, 32'h0, 32'h0},
        '{0, 8'h08, 32'h0, 32'h0}, '{0, 8'h0c, 32'h0, 32'h1},
        '{0, 8'h10, 32'h0, 32'h0}, '{0, 8'h14, 32'h0, 32'h0},
        '{1, 8'h00, 32'hffff, 32'h0}, '{1, 8'h14, 32'h1, 32'h1},
        '{1, 8'h00, 32'hffff, 32'hffff}, '{1, 8'h04, 32'h1fff, 32'h1fff},
        '{1, 8'h08, 32'ha5a5, 32'ha5a5}, '{1, 8'h0c, 32'h0, 32'h1},
        '{1, 8'h0c, 32'h1ffe, 32'h1fff}, '{1, 8'h10, 32'h1f, 32'h0},
        '{1, 8'h1c, 32'hf, 32'hf}};

    always #50 core_clk = ~core_clk;

    ipw_window_regs u_ipw_window_regs (.core_clk(core_clk), .rst_n(rst_n), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .vertical_sync(vertical_sync),
        .horizontal_sync(horizontal_sync), .engine_sts(engine_sts),
        .register_interface_clock(register_interface_clock),
        .pixel_clock_gate(pixel_clock_gate), .enables(enables), .window(window), .irq(irq));

    ipw_sensor_model u_ipw_sensor_model (.core_clk(core_clk), .frame_req(frame_req),
        .vertical_sync(vertical_sync), .horizontal_sync(horizontal_sync),
        .line_idx(line_idx), .frame_busy(frame_busy));

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk32(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask

    // setup then access; request held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge core_clk);
        end
        if (n == 50) chk32(32'h1, 32'h0);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    // ************************************************************
    // monitors and timeout
    // ************************************************************
    always @(posedge core_clk) begin
        cycles++;
        if (window.in_window === 1'b1) begin
            win_cnt++;
            if (first_line < 0) first_line = line_idx;
        end
        if (window.frame_start === 1'b1) fs_cnt++;
        if (window.line_active === 1'b1) ln_cnt++;
        if (window.pixel_active === 1'b1) px_cnt++;
        if (cycles == 20000) begin
            failures++;
            $display("ERROR %0t timeout", $time);
            print_verdict();
        end
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        // reserved bits are always written as zero
        foreach (rows[i]) begin
            if (rows[i].wr) apb(1'b1, rows[i].a, rows[i].d);
            apb(1'b0, rows[i].a, 32'h0);
            chk32(rd, rows[i].e);
        end
        chk32({28'h0, pixel_clock_gate}, 32'hf);
        $display("register rows done");
        apb(1'b0, 8'h30, 32'h0);
        chk32(rd, 32'h0);
        chk32({31'h0, err}, 32'h1);
        apb(1'b1, 8'h14, 32'h0);
        apb(1'b1, 8'h00, 32'h2);
        apb(1'b1, 8'h18, 32'h1);
        apb(1'b1, 8'h1c, 32'h5);
        apb(1'b0, 8'h00, 32'h0);
        chk32(rd, 32'hffff);
        apb(1'b0, 8'h18, 32'h0);
        chk32(rd, 32'h1);
        chk32({30'h0, register_interface_clock, enables.pipe_enable}, 32'h1);
        chk32({28'h0, enables}, 32'h1);
        chk32({28'h0, pixel_clock_gate}, 32'h5);
        $display("gate test done");
        for (int i = 0; i < 5; i++) begin
            engine_sts <= ipw_pkg::ipw_engine_sts_t'(5'h1 << i);
            @(posedge core_clk);
            apb(1'b0, 8'h10, 32'h0);
            chk32(rd, 32'h1 << i);
        end
        engine_sts <= '0;
        $display("status test done");
        apb(1'b1, 8'h14, 32'h1);
        apb(1'b1, 8'h00, 32'h2);
        apb(1'b1, 8'h04, 32'h1);
        apb(1'b1, 8'h08, 32'h3);
        apb(1'b1, 8'h0c, 32'h4);
        apb(1'b1, 8'h24, 32'h1);
        apb(1'b0, 8'h20, 32'h0);
        // irq comes from registers, settled one edge after the task's last transfer
        chk32({31'h0, irq}, 32'h0);
        win_cnt = 0;
        fs_cnt = 0;
        ln_cnt = 0;
        px_cnt = 0;
        frame_req <= 1'b1;
        @(posedge core_clk);
        frame_req <= 1'b0;
        repeat (2) @(posedge core_clk);
        for (int n = 0; n < 500 && frame_busy !== 1'b0; n++) @(posedge core_clk);
        repeat (8) @(posedge core_clk);
        chk32(win_cnt, 12);
        chk32(ln_cnt, 40);
        chk32(px_cnt, 36);
        chk32(first_line, 2);
        chk32(fs_cnt, 1);
        chk32({31'h0, irq}, 32'h1);
        apb(1'b1, 8'h24, 32'h0);
        chk32({31'h0, irq}, 32'h0);
        apb(1'b1, 8'h24, 32'h1);
        chk32({31'h0, irq}, 32'h1);
        apb(1'b0, 8'h20, 32'h0);
        chk32(rd, 32'h3);
        chk32({31'h0, irq}, 32'h0);
        $display("window and interrupt test done");
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        apb(1'b0, 8'h00, 32'h0);
        chk32(rd, 32'h0);
        apb(1'b0, 8'h0c, 32'h0);
        chk32(rd, 32'h1);
        $display("second reset test done");
        print_verdict();
    end
endmodule
